// [hw/rfbw_pkg.sv]
// rfbw_pkg: constants and state encoding for the fast buffered write path
// assumes a single cpu clock domain, one T-state per clock
package rfbw_pkg;
    localparam int IW_W = 2;
    localparam int DW_W = 3;
    localparam int MS_W = 2;
    localparam int PC_W = 16;
    localparam logic [MS_W-1:0] MS_DMEM = 2'h0;
    localparam logic [MS_W-1:0] MS_IMEM = 2'h1;
    localparam logic [MS_W-1:0] MS_PCLO = 2'h2;
    localparam logic [MS_W-1:0] MS_PCHI = 2'h3;
    localparam logic [PC_W-1:0] PC_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] RIC_RST = 8'h00;
    localparam int RIC_MS_LSB = 0;
    localparam logic [PC_W-1:0] PC_ONE = 16'h0001;
    localparam logic [IW_W-1:0] IW_ONE = 2'h1;
    localparam logic [DW_W-1:0] DW_ONE = 3'h1;
    typedef enum logic [11:0] {
        ST_IDLE1 = 12'h001,
        ST_IDLE2 = 12'h002,
        ST_TAKE  = 12'h004,
        ST_SETUP = 12'h008,
        ST_RIC   = 12'h010,
        ST_PCLO  = 12'h020,
        ST_PCHI  = 12'h040,
        ST_DMEM  = 12'h080,
        ST_IMEM  = 12'h100,
        ST_TERM  = 12'h200,
        ST_FINAL = 12'h400,
        ST_HOLD  = 12'h800
    } rfbw_state_t;
endpackage

// [hw/rfbw_remote_write.sv]
// rfbw_remote_write: remote access arbiter, fast buffered write mode
// assumes the remote side drives the shared memory buses during access
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - idle until enable and write request
// - hold second idle while lockout or local grant
// - grant local requests while buses free and lockIn_n high
// - acknowledge low on qualified write request
// - takeover next clock without lockout or request
// - no local grants until termination
// - float buses half T after takeover
// - setup: owner high, load wait counters
// - setup strobe instruction write on high byte
// - command high writes control register
// - select 10/11 writes pc low/high
// - select 00 strobes data write, waits
// - instruction bytes latch low, write word
// - reset or select 01 clears flag
// - termination: acknowledge high after waits
// - final: owner low, float first half
// - final: toggle flag after an instruction write, increment pc after the high byte
// - hold until request drops, then idle
// - one T delay before switching bus
// - strobe and acknowledge release together
module rfbw_remote_write (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic remoteAccessEnable,
    input wire logic remoteWriteRequest_n,
    input wire logic remoteWait_n,
    input wire logic cmdSelect,
    input wire logic [7:0] remoteData,
    input wire logic localLockoutBit,
    input wire logic lockIn_n,
    input wire logic localBusRequest,
    input wire logic [rfbw_pkg::IW_W-1:0] instrWaitField,
    input wire logic [rfbw_pkg::DW_W-1:0] dataWaitField,
    output logic localBusGrant,
    output logic localWaitReq,
    output logic transferAcknowledge,
    output logic localBusOwner_n,
    output logic busFloat,
    output logic dataMemWriteStrobe_n,
    output logic instrMemWriteStrobe_n,
    output logic [15:0] instrWord,
    output logic [rfbw_pkg::PC_W-1:0] programCounter,
    output logic [7:0] remoteIfControl,
    output logic [rfbw_pkg::MS_W-1:0] memorySelectField,
    output logic highByteFlag
);
    import rfbw_pkg::*;

    // remote control pins come from outside, so two flops before use; remoteData is used directly
    logic [1:0] wrSync_r, waitSync_r, cmdSync_r, raeSync_r, lockSync_r;
    logic wrReq, waitHigh, cmdHigh, lockHigh;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wrSync_r <= 2'h0;
            waitSync_r <= 2'h3;
            cmdSync_r <= 2'h0;
            raeSync_r <= 2'h0;
            lockSync_r <= 2'h3;
        end else begin
            wrSync_r <= {wrSync_r[0], ~remoteWriteRequest_n};
            waitSync_r <= {waitSync_r[0], remoteWait_n};
            cmdSync_r <= {cmdSync_r[0], cmdSelect};
            raeSync_r <= {raeSync_r[0], remoteAccessEnable};
            lockSync_r <= {lockSync_r[0], lockIn_n};
        end
    end
    assign wrReq = raeSync_r[1] & wrSync_r[1];
    assign waitHigh = waitSync_r[1];
    assign cmdHigh = cmdSync_r[1];
    assign lockHigh = lockSync_r[1];

    rfbw_state_t state_r, state_nxt;
    logic [IW_W-1:0] iwCnt_r, iwCnt_nxt;
    logic [DW_W-1:0] dwCnt_r, dwCnt_nxt;
    logic grant_r, grant_nxt;
    logic hib_r, hib_nxt;
    logic wasImem_r, wasImem_nxt;
    logic wasHigh_r, wasHigh_nxt;
    logic [7:0] lowLatch_r, lowLatch_nxt;
    logic [15:0] iword_r, iword_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic [7:0] ric_r, ric_nxt;
    logic [7:0] ricActive_r, ricActive_nxt;
    logic ricPend_r, ricPend_nxt;
    logic floatHalf_r;
    logic idle, msImem, grantOk;

    assign idle = (state_r == ST_IDLE1) || (state_r == ST_IDLE2);
    // final and hold states free the buses, so a grant given there must stand
    assign grantOk = idle || state_r == ST_FINAL || state_r == ST_HOLD;
    assign msImem = ricActive_r[RIC_MS_LSB +: MS_W] == MS_IMEM;

    always_comb begin
        state_nxt = state_r;
        iwCnt_nxt = iwCnt_r;
        dwCnt_nxt = dwCnt_r;
        grant_nxt = grant_r;
        hib_nxt = hib_r;
        wasImem_nxt = wasImem_r;
        wasHigh_nxt = wasHigh_r;
        lowLatch_nxt = lowLatch_r;
        iword_nxt = iword_r;
        pc_nxt = pc_r;
        ric_nxt = ric_r;
        ricActive_nxt = ric_r;
        ricPend_nxt = 1'b0;
        // mode change lands one T after the control write completes
        if (!ricPend_r) begin
            ricActive_nxt = ric_r;
        end else begin
            ricActive_nxt = ricActive_r;
        end
        // local grant only from idle, final or hold states, never mid access
        if (grantOk && lockHigh) begin
            grant_nxt = localBusRequest;
        end else if (!grantOk) begin
            grant_nxt = 1'b0;
        end
        case (state_r)
            ST_IDLE1: begin
                if (wrReq) begin
                    if (localLockoutBit || grant_r || localBusRequest) begin
                        state_nxt = ST_IDLE2;
                    end else begin
                        state_nxt = ST_TAKE;
                    end
                end
            end
            ST_IDLE2: begin
                if (!wrReq) begin
                    state_nxt = ST_IDLE1;
                end else if (!localLockoutBit && !grant_r &&
                             !localBusRequest) begin
                    state_nxt = ST_TAKE;
                end
            end
            ST_TAKE: begin
                state_nxt = ST_SETUP;
            end
            ST_SETUP: begin
                iwCnt_nxt = instrWaitField;
                dwCnt_nxt = dataWaitField;
                wasImem_nxt = 1'b0;
                wasHigh_nxt = 1'b0;
                if (cmdHigh) begin
                    state_nxt = ST_RIC;
                end else begin
                    case (ricActive_r[RIC_MS_LSB +: MS_W])
                        MS_PCLO: state_nxt = ST_PCLO;
                        MS_PCHI: state_nxt = ST_PCHI;
                        MS_DMEM: state_nxt = ST_DMEM;
                        default: state_nxt = ST_IMEM;
                    endcase
                end
            end
            ST_RIC: begin
                ric_nxt = remoteData;
                ricPend_nxt = 1'b1;
                if (remoteData[RIC_MS_LSB +: MS_W] == MS_IMEM) begin
                    hib_nxt = 1'b0;
                end
                if (waitHigh) begin
                    state_nxt = ST_TERM;
                end
            end
            ST_PCLO: begin
                pc_nxt = {pc_r[15:8], remoteData};
                if (waitHigh) begin
                    state_nxt = ST_TERM;
                end
            end
            ST_PCHI: begin
                pc_nxt = {remoteData, pc_r[7:0]};
                if (waitHigh) begin
                    state_nxt = ST_TERM;
                end
            end
            ST_DMEM: begin
                // programmed waits first, then the remote wait pin
                if (dwCnt_r != '0) begin
                    dwCnt_nxt = dwCnt_r - DW_ONE;
                end else if (waitHigh) begin
                    state_nxt = ST_TERM;
                end
            end
            ST_IMEM: begin
                wasImem_nxt = 1'b1;
                wasHigh_nxt = hib_r;
                if (!hib_r) begin
                    lowLatch_nxt = remoteData;
                end else begin
                    iword_nxt = {remoteData, lowLatch_r};
                end
                if (iwCnt_r != '0) begin
                    iwCnt_nxt = iwCnt_r - IW_ONE;
                end else if (waitHigh) begin
                    state_nxt = ST_TERM;
                end
            end
            ST_TERM: begin
                state_nxt = ST_FINAL;
            end
            ST_FINAL: begin
                if (wasImem_r) begin
                    hib_nxt = ~hib_r;
                    if (wasHigh_r) begin
                        pc_nxt = pc_r + PC_ONE;
                    end
                end
                state_nxt = wrReq ? ST_HOLD : ST_IDLE1;
            end
            ST_HOLD: begin
                if (!wrReq) begin
                    state_nxt = ST_IDLE1;
                end
            end
            default: state_nxt = ST_IDLE1;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_r <= ST_IDLE1;
            iwCnt_r <= '0;
            dwCnt_r <= '0;
            grant_r <= 1'b0;
            hib_r <= 1'b0;
            wasImem_r <= 1'b0;
            wasHigh_r <= 1'b0;
            lowLatch_r <= BYTE_RST;
            iword_r <= 16'h0000;
            pc_r <= PC_RST;
            ric_r <= RIC_RST;
            ricActive_r <= RIC_RST;
            ricPend_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            iwCnt_r <= iwCnt_nxt;
            dwCnt_r <= dwCnt_nxt;
            grant_r <= grant_nxt;
            hib_r <= hib_nxt;
            wasImem_r <= wasImem_nxt;
            wasHigh_r <= wasHigh_nxt;
            lowLatch_r <= lowLatch_nxt;
            iword_r <= iword_nxt;
            pc_r <= pc_nxt;
            ric_r <= ric_nxt;
            ricActive_r <= ricActive_nxt;
            ricPend_r <= ricPend_nxt;
        end
    end

    // half-T float edges are taken on the falling clock edge
    always_ff @(negedge clk_sys) begin
        if (!resetn) begin
            floatHalf_r <= 1'b0;
        end else begin
            // released mid-final, so local grants meet quiet buses
            floatHalf_r <= !grantOk;
        end
    end

    assign localBusGrant = grant_r;
    // cpu data accesses stall in remote wait states outside idle, final and hold
    assign localWaitReq = localBusRequest && !grant_r && !grantOk;
    // ack goes low combinationally on the qualified request
    assign transferAcknowledge = !((wrReq && (idle || state_r == ST_TAKE)) ||
        state_r == ST_SETUP || state_r == ST_RIC || state_r == ST_PCLO ||
        state_r == ST_PCHI || state_r == ST_DMEM || state_r == ST_IMEM);
    // high while the remote owns the buses
    assign localBusOwner_n = state_r == ST_SETUP || state_r == ST_RIC ||
        state_r == ST_PCLO || state_r == ST_PCHI || state_r == ST_DMEM ||
        state_r == ST_IMEM || state_r == ST_TERM;
    assign busFloat = floatHalf_r;
    assign dataMemWriteStrobe_n = !(state_r == ST_DMEM);
    assign instrMemWriteStrobe_n = !(hib_r && ((state_r == ST_SETUP &&
        msImem && !cmdHigh) || state_r == ST_IMEM));
    assign instrWord = iword_r;
    assign programCounter = pc_r;
    assign remoteIfControl = ricActive_r;
    assign memorySelectField = ricActive_r[RIC_MS_LSB +: MS_W];
    assign highByteFlag = hib_r;

    a_idle_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == ST_IDLE1 && !wrReq |=> state_r == ST_IDLE1)
        else $error("idle left without request");
    a_lock_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        idle && wrReq && localLockoutBit |=> state_r != ST_TAKE)
        else $error("takeover under lockout");
    a_ack_low: assert property (@(posedge clk_sys) disable iff (!resetn)
        idle && wrReq |-> !transferAcknowledge)
        else $error("ack not low on request");
    a_take_setup: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == ST_TAKE |=> state_r == ST_SETUP && localBusOwner_n)
        else $error("setup not after takeover");
    a_no_grant: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == ST_DMEM |-> !localBusGrant)
        else $error("grant during access");
    a_term_ack: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == ST_TERM |-> transferAcknowledge && localBusOwner_n)
        else $error("termination outputs wrong");
    a_final_next: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == ST_TERM |=> state_r == ST_FINAL && !localBusOwner_n)
        else $error("final not after term");
    a_hib_toggle: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == ST_FINAL && wasImem_r |=> hib_r != $past(hib_r))
        else $error("high byte flag not toggled");
    a_pc_inc: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == ST_FINAL && wasImem_r && wasHigh_r
        |=> pc_r == $past(pc_r) + PC_ONE)
        else $error("pc not incremented");
    a_dmem_waits: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == ST_DMEM && dwCnt_r != '0 |=> state_r == ST_DMEM)
        else $error("data waits skipped");
    c_dmem: cover property (@(posedge clk_sys) state_r == ST_DMEM);
    c_imem_hi: cover property (@(posedge clk_sys) state_r == ST_IMEM && hib_r);
    c_ric: cover property (@(posedge clk_sys) state_r == ST_RIC);
    c_hold: cover property (@(posedge clk_sys) state_r == ST_HOLD);
endmodule
`default_nettype wire

// [test/remote_fast_buffered_write_tb_top.sv]
// remote_fast_buffered_write_tb_top: self-checking bench for rfbw_remote_write
// assumes rfbw_pkg compiled first and the remote model drives the port
`timescale 1ns/100ps
`default_nettype none
module remote_fast_buffered_write_tb_top;
    import rfbw_pkg::*;
    typedef struct {
        logic [15:0] pc;
        logic [7:0] remote_interface_control;
        logic flag;
        logic [15:0] word;
        int nD, nI, nOwn;
        bit stall;
    } rfbw_note_t;
    logic clk_sys = 1'b0, resetn = 1'b0, go = 1'b0, goCmd = 1'b0;
    logic enableIn = 1'b1, localLockoutBit = 1'b0, localBusRequest = 1'b0;
    logic lockIn_n = 1'b1;
    logic [7:0] goData = 8'h00, remoteData;
    logic [4:0] stallCycles = 5'h00;
    logic [IW_W-1:0] instrWaitField = 2'h0;
    logic [DW_W-1:0] dataWaitField = 3'h0;
    logic remoteAccessEnable, remoteWriteRequest_n, remoteWait_n, cmdSelect;
    logic busy, localBusGrant, localWaitReq, transferAcknowledge;
    logic localBusOwner_n, busFloat, dataMemWriteStrobe_n;
    logic instrMemWriteStrobe_n, highByteFlag, busyPrev = 1'b0;
    logic [15:0] instrWord, programCounter, pcE, wordE;
    logic [7:0] remoteIfControl, ricE, latE;
    logic [MS_W-1:0] memorySelectField;
    logic flagE;
    int n_mismatch = 0, checked = 0, seed = 5, nD = 0, nI = 0, nOwn = 0;
    int tail = 0, k;
    rfbw_note_t notes[$];
    rfbw_note_t e;
    always #5 clk_sys = ~clk_sys;
    rfbw_remote_write u_dut (.clk_sys(clk_sys), .resetn(resetn),
        .remoteAccessEnable(remoteAccessEnable),
        .remoteWriteRequest_n(remoteWriteRequest_n),
        .remoteWait_n(remoteWait_n), .cmdSelect(cmdSelect),
        .remoteData(remoteData), .localLockoutBit(localLockoutBit),
        .lockIn_n(lockIn_n), .localBusRequest(localBusRequest),
        .instrWaitField(instrWaitField), .dataWaitField(dataWaitField),
        .localBusGrant(localBusGrant), .localWaitReq(localWaitReq),
        .transferAcknowledge(transferAcknowledge),
        .localBusOwner_n(localBusOwner_n), .busFloat(busFloat),
        .dataMemWriteStrobe_n(dataMemWriteStrobe_n),
        .instrMemWriteStrobe_n(instrMemWriteStrobe_n),
        .instrWord(instrWord), .programCounter(programCounter),
        .remoteIfControl(remoteIfControl),
        .memorySelectField(memorySelectField), .highByteFlag(highByteFlag));
    rfbw_remote_proc u_remote (.clk_sys(clk_sys), .resetn(resetn), .go(go),
        .goCmd(goCmd), .goData(goData), .stallCycles(stallCycles),
        .enableIn(enableIn), .transferAcknowledge(transferAcknowledge),
        .remoteAccessEnable(remoteAccessEnable),
        .remoteWriteRequest_n(remoteWriteRequest_n),
        .remoteWait_n(remoteWait_n), .cmdSelect(cmdSelect),
        .remoteData(remoteData), .busy(busy));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // expectation worked out from the select in force, then the write begins
    task automatic start(input logic cmd, input logic [7:0] d,
                         input logic [4:0] st);
        rfbw_note_t n;
        logic [2:0] dw;
        logic [1:0] iw;
        dw = 3'($random(seed));
        iw = 2'($random(seed));
        n.nD = 0;
        n.nI = 0;
        n.nOwn = 3;
        n.stall = (st != 5'h00);
        if (cmd) begin
            ricE = d;
            if (d[1:0] == MS_IMEM) flagE = 1'b0;
        end else begin
            case (ricE[1:0])
                MS_PCLO: pcE[7:0] = d;
                MS_PCHI: pcE[15:8] = d;
                MS_DMEM: begin
                    n.nD = 1 + int'(dw);
                    n.nOwn = 3 + int'(dw);
                end
                default: begin
                    n.nOwn = 3 + int'(iw);
                    if (flagE) begin
                        wordE = {d, latE};
                        n.nI = 2 + int'(iw);
                        pcE = pcE + PC_ONE;
                    end else begin
                        latE = d;
                    end
                    flagE = !flagE;
                end
            endcase
        end
        n.pc = pcE;
        n.remote_interface_control = ricE;
        n.flag = flagE;
        n.word = wordE;
        notes.push_back(n);
        @(posedge clk_sys);
        go <= 1'b1;
        goCmd <= cmd;
        goData <= d;
        stallCycles <= st;
        dataWaitField <= dw;
        instrWaitField <= iw;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask
    task automatic finish;
        int i;
        i = 0;
        repeat (2) @(posedge clk_sys);
        while (busy && i < 300) begin
            @(posedge clk_sys);
            i++;
        end
        repeat (6) @(posedge clk_sys);
        if (busy) begin
            n_mismatch++;
            test_done();
        end
    endtask
    task automatic xfer(input logic cmd, input logic [7:0] d);
        start(cmd, d, 5'h00);
        finish();
    endtask
    // monitor: counts strobe and owner cycles, checks when a write settles
    initial forever begin
        @(posedge clk_sys);
        #1;
        if (busy || tail > 0) begin
            nD += int'(!dataMemWriteStrobe_n);
            nI += int'(!instrMemWriteStrobe_n);
            nOwn += int'(localBusOwner_n);
        end
        if (busyPrev && !busy) tail = 3;
        else if (tail == 1 && notes.size() > 0) begin
            tail = 0;
            e = notes.pop_front();
            chk(programCounter, e.pc);
            chk({remoteIfControl, memorySelectField}, {e.remote_interface_control, e.remote_interface_control[1:0]});
            chk(highByteFlag, e.flag);
            if (e.nI != 0) chk(instrWord, e.word);
            chk(nI, e.nI);
            if (e.stall) chk(nD > e.nD, 1'b1);
            else begin
                chk(nD, e.nD);
                chk(nOwn, e.nOwn);
            end
            nD = 0;
            nI = 0;
            nOwn = 0;
        end else if (tail > 0) begin
            tail--;
        end
        busyPrev = busy;
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_mismatch++;
        test_done();
    end
    initial begin
        pcE = PC_RST;
        ricE = RIC_RST;
        latE = BYTE_RST;
        wordE = 16'h0000;
        flagE = 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk({transferAcknowledge, dataMemWriteStrobe_n, instrMemWriteStrobe_n,
            localBusGrant, highByteFlag, localBusOwner_n}, 6'h38);
        @(posedge clk_sys);
        lockIn_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        localBusRequest <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(localBusGrant, 1'b0);
        @(posedge clk_sys);
        lockIn_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(localBusGrant, 1'b1);
        @(posedge clk_sys);
        localBusRequest <= 1'b0;
        repeat (3) @(posedge clk_sys);
        for (k = 0; k < 12; k++) begin
            xfer(1'b1, {6'($random(seed)), 2'(k)});
            repeat (3) xfer(1'b0, 8'($random(seed)));
        end
        xfer(1'b1, {6'h00, MS_DMEM});
        // stalled access: local request must wait it out
        start(1'b0, 8'hA5, 5'd14);
        repeat (8) @(posedge clk_sys);
        localBusRequest <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({localBusGrant, localWaitReq, busFloat, transferAcknowledge}, 4'b0110);
        finish();
        #1;
        chk(localBusGrant, 1'b1);
        @(posedge clk_sys);
        localBusRequest <= 1'b0;
        enableIn <= 1'b0;
        start(1'b0, 8'h3C, 5'h00);
        repeat (8) @(posedge clk_sys);
        #1;
        chk({transferAcknowledge, localBusOwner_n, busFloat}, 3'b100);
        @(posedge clk_sys);
        enableIn <= 1'b1;
        localLockoutBit <= 1'b1;
        // the held write now waits in the second idle state
        repeat (8) @(posedge clk_sys);
        #1;
        chk({transferAcknowledge, localBusOwner_n, busFloat}, 3'b000);
        @(posedge clk_sys);
        localLockoutBit <= 1'b0;
        finish();
        test_done();
    end
endmodule
`default_nettype wire

// [test/rfbw_remote_proc.sv]
// rfbw_remote_proc: remote processor model, one buffered write at a time
// assumes go is a one-cycle pulse given only while busy is low
`timescale 1ns/100ps
`default_nettype none
module rfbw_remote_proc (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic go,
    input wire logic goCmd,
    input wire logic [7:0] goData,
    input wire logic [4:0] stallCycles,
    input wire logic enableIn,
    input wire logic transferAcknowledge,
    output logic remoteAccessEnable,
    output logic remoteWriteRequest_n,
    output logic remoteWait_n,
    output logic cmdSelect,
    output logic [7:0] remoteData,
    output logic busy
);
    logic sawLow_r;
    logic [4:0] stall_r;
    always_ff @(posedge clk_sys) begin
        remoteAccessEnable <= enableIn;
        if (!resetn) begin
            remoteWriteRequest_n <= 1'b1;
            remoteWait_n <= 1'b1;
            cmdSelect <= 1'b0;
            remoteData <= 8'h00;
            stall_r <= 5'h00;
            sawLow_r <= 1'b0;
            busy <= 1'b0;
        end else if (!busy) begin
            if (!go) begin
                remoteWait_n <= 1'b1;
            end else begin
                remoteWriteRequest_n <= 1'b0;
                cmdSelect <= goCmd;
                remoteData <= goData;
                remoteWait_n <= (stallCycles == 5'h00);
                stall_r <= stallCycles;
                sawLow_r <= 1'b0;
                busy <= 1'b1;
            end
        end else begin
            // wait pulled low from the start, well ahead of the sync delay
            remoteWait_n <= (stall_r == 5'h00);
            if (stall_r != 5'h00) stall_r <= stall_r - 5'h01;
            if (!transferAcknowledge) sawLow_r <= 1'b1;
            // end the cycle once ack is back high; released lines change
            if (sawLow_r && transferAcknowledge) begin
                remoteWriteRequest_n <= 1'b1;
                cmdSelect <= ~cmdSelect;
                remoteData <= ~remoteData;
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire
